// >>> common/supply_monitor_pkg.sv
// Purpose: Shared constants for the supply monitor flag logic
// Assumes: Core clock of 250 MHz; eight-bit special-function register port
// Notes: Trip levels are in millivolts for the comparator selection outputs
package supply_monitor_pkg;
   localparam logic [7:0] CTRL_ADDR = 8'hdf;
   localparam logic [7:0] CTRL_RESET = 8'hde;
   localparam int BIT_DCMP = 7;
   localparam int BIT_ACMP = 6;
   localparam int BIT_FLAG = 5;
   localparam int BIT_DTRIP_HI = 4;
   localparam int BIT_DTRIP_LO = 3;
   localparam int BIT_ATRIP_HI = 2;
   localparam int BIT_ATRIP_LO = 1;
   localparam int BIT_ENABLE = 0;
   localparam logic [12:0] TRIP_MV_SEL0 = 13'd4630;
   localparam logic [12:0] TRIP_MV_SEL1 = 13'd3080;
   localparam logic [12:0] TRIP_MV_SEL2 = 13'd2930;
   localparam logic [12:0] TRIP_MV_SEL3 = 13'd2630;
   localparam longint CLK_HZ = 250000000;
   localparam longint CLEAR_TIME_MS = 250;
   localparam longint CLEAR_CYCLES = (CLEAR_TIME_MS * CLK_HZ) / 1000;
   localparam int GLITCH_CYCLES = 16;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LOW = 3'b010,
      ST_WAIT = 3'b100
   } mon_state_t;
endpackage

// >>> hw/glitch_filter.sv
// Purpose: Debounce one comparator level after synchronisation
// Assumes: Input already synchronised to CLK
// Notes: Output changes only after LEN stable cycles
`timescale 1ns/1ps
module glitch_filter #(
   parameter int LEN = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic din,
   output logic dout
);
   logic [$clog2(LEN+1)-1:0] cnt_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         dout <= 1'b1;
      end else if (din == dout) begin
         cnt_r <= '0;
      end else if (cnt_r == ($clog2(LEN+1))'(LEN - 1)) begin
         cnt_r <= '0;
         dout <= din;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end
endmodule

// >>> hw/supply_monitor_interrupt.sv
// Purpose: Control register and low-supply flag logic of the supply monitor
// Assumes: Comparator levels arrive asynchronously; register port on core clock
// Notes: Flag clears itself after the rails return high while enabled and stay high for the clear time
//
// Contract
// - When enabled, both rails are watched against one of four selectable trip levels.
// - The flag raises the core interrupt only while the interrupt enable input is set.
// - Comparator inputs are filtered so short glitches never set the flag.
// - Bits 7 and 6 read the live digital and analog comparator levels, 1 meaning above.
// - The flag in bit 5 is set whenever the monitor is enabled and either comparator level is low.
// - Once both levels return high after a low level seen while enabled and stay so, a 250 ms count runs and then clears the flag.
// - Software writes to the flag take effect, but a clear is ignored while enabled with a level low and a set is lost in the cycle the count expires.
// - Bits 4:3 select the digital trip level 4.63, 3.08, 2.93 or 2.63 V.
// - Bits 2:1 select the analog trip level with the same encoding.
// - The register resets to 0xde and is written only as a whole byte.
// - A low-supply interrupt clears the watchdog enable.
`timescale 1ns/1ps
module supply_monitor_interrupt
   import supply_monitor_pkg::*;
#(
   parameter longint CLEAR_COUNT = CLEAR_CYCLES,
   parameter int FILTER_LEN = GLITCH_CYCLES
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic [7:0] SFR_ADDR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   output logic [7:0] SFR_RDATA,
   input wire logic DIG_CMP,
   input wire logic ANA_CMP,
   input wire logic INT_ENABLE,
   output logic [12:0] DIG_TRIP_MV,
   output logic [12:0] ANA_TRIP_MV,
   output logic LOW_SUPPLY_IRQ,
   output logic WDOG_ENABLE_CLR
);
   localparam int CW = $clog2(CLEAR_COUNT + 1);

   function automatic logic [12:0] trip_mv(input logic [1:0] sel);
      case (sel)
         2'h0: trip_mv = TRIP_MV_SEL0;
         2'h1: trip_mv = TRIP_MV_SEL1;
         2'h2: trip_mv = TRIP_MV_SEL2;
         default: trip_mv = TRIP_MV_SEL3;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Reset release and input synchronisers
   logic [1:0] rst_sync_r;
   logic rst_n;
   logic [1:0] dcmp_sync_r;
   logic [1:0] acmp_sync_r;
   logic dcmp_f;
   logic acmp_f;

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         dcmp_sync_r <= 2'h3;
         acmp_sync_r <= 2'h3;
      end else begin
         dcmp_sync_r <= {dcmp_sync_r[0], DIG_CMP};
         acmp_sync_r <= {acmp_sync_r[0], ANA_CMP};
      end
   end

   glitch_filter #(.LEN(FILTER_LEN)) dfilt (
      .clk(CLK),
      .rst_n(rst_n),
      .din(dcmp_sync_r[1]),
      .dout(dcmp_f)
   );

   glitch_filter #(.LEN(FILTER_LEN)) afilt (
      .clk(CLK),
      .rst_n(rst_n),
      .din(acmp_sync_r[1]),
      .dout(acmp_f)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Control register
   logic [3:0] trip_sel_r;
   logic enable_r;
   logic flag_r;
   logic flag_nxt;
   logic any_low;
   logic ctrl_wr;

   assign ctrl_wr = SFR_WR && (SFR_ADDR == CTRL_ADDR);
   assign any_low = !dcmp_f || !acmp_f;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         trip_sel_r <= CTRL_RESET[BIT_DTRIP_HI:BIT_ATRIP_LO];
         enable_r <= CTRL_RESET[BIT_ENABLE];
      end else if (ctrl_wr) begin
         trip_sel_r <= SFR_WDATA[BIT_DTRIP_HI:BIT_ATRIP_LO];
         enable_r <= SFR_WDATA[BIT_ENABLE];
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         DIG_TRIP_MV <= TRIP_MV_SEL0;
         ANA_TRIP_MV <= TRIP_MV_SEL0;
      end else begin
         DIG_TRIP_MV <= trip_mv(trip_sel_r[3:2]);
         ANA_TRIP_MV <= trip_mv(trip_sel_r[1:0]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clearing timer state machine
   mon_state_t state_r;
   mon_state_t state_nxt;
   logic [CW-1:0] cnt_r;
   logic expire;

   assign expire = (state_r == ST_WAIT) && (cnt_r == CW'(CLEAR_COUNT - 1));

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (enable_r && any_low) begin
               state_nxt = ST_LOW;
            end
         end
         ST_LOW: begin
            if (!enable_r) begin
               state_nxt = ST_IDLE;
            end else if (!any_low) begin
               state_nxt = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (!enable_r) begin
               state_nxt = ST_IDLE;
            end else if (any_low) begin
               state_nxt = ST_LOW;
            end else if (expire) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else if (state_r == ST_WAIT && state_nxt == ST_WAIT) begin
         cnt_r <= cnt_r + 1'b1;
      end else begin
         cnt_r <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Low-supply flag: hardware set wins over a software clear
   always_comb begin
      flag_nxt = flag_r;
      if (ctrl_wr) begin
         flag_nxt = SFR_WDATA[BIT_FLAG];
      end
      if (expire && !any_low) begin
         flag_nxt = 1'b0;
      end
      if (enable_r && any_low) begin
         flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         flag_r <= CTRL_RESET[BIT_FLAG];
      end else begin
         flag_r <= flag_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   logic [7:0] ctrl_view;
   assign ctrl_view = {dcmp_f, acmp_f, flag_r, trip_sel_r, enable_r};

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         SFR_RDATA <= 8'h00;
         LOW_SUPPLY_IRQ <= 1'b0;
         WDOG_ENABLE_CLR <= 1'b0;
      end else begin
         SFR_RDATA <= (SFR_RD && SFR_ADDR == CTRL_ADDR) ? ctrl_view : 8'h00;
         LOW_SUPPLY_IRQ <= flag_nxt && INT_ENABLE;
         WDOG_ENABLE_CLR <= flag_nxt && INT_ENABLE && !LOW_SUPPLY_IRQ;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence rail_low_s;
      enable_r && any_low;
   endsequence

   // Interrupt matches the flag in the cycle after the enable input is seen set
   sequence irq_seen_s;
      ##1 (LOW_SUPPLY_IRQ == flag_r);
   endsequence

   flag_set_a: assert property (@(posedge CLK) disable iff (!rst_n)
      rail_low_s |=> flag_r)
      else $error("flag not set on low rail");
   no_clear_low_a: assert property (@(posedge CLK) disable iff (!rst_n)
      (ctrl_wr && !SFR_WDATA[BIT_FLAG] && any_low && enable_r) |=> flag_r)
      else $error("flag cleared while rail low");
   irq_gate_a: assert property (@(posedge CLK) disable iff (!rst_n)
      INT_ENABLE |-> irq_seen_s)
      else $error("interrupt does not follow flag");
   irq_mask_a: assert property (@(posedge CLK) disable iff (!rst_n)
      !INT_ENABLE |=> !LOW_SUPPLY_IRQ)
      else $error("interrupt raised while masked");
   auto_clear_a: assert property (@(posedge CLK) disable iff (!rst_n)
      (expire && !any_low && !ctrl_wr && enable_r) |=> !flag_r)
      else $error("flag not cleared at expiry");
   restart_a: assert property (@(posedge CLK) disable iff (!rst_n)
      (state_r == ST_WAIT && any_low && enable_r) |=> (cnt_r == '0 && state_r == ST_LOW))
      else $error("count not restarted");
   disabled_idle_a: assert property (@(posedge CLK) disable iff (!rst_n)
      !enable_r |=> (cnt_r == '0 && state_r == ST_IDLE))
      else $error("count runs while disabled");
   live_bits_a: assert property (@(posedge CLK) disable iff (!rst_n)
      (SFR_RD && SFR_ADDR == CTRL_ADDR) |=>
         SFR_RDATA[BIT_DCMP:BIT_ACMP] == $past({dcmp_f, acmp_f}))
      else $error("comparator bits wrong");
   wdog_clr_a: assert property (@(posedge CLK) disable iff (!rst_n)
      $rose(LOW_SUPPLY_IRQ) |-> WDOG_ENABLE_CLR)
      else $error("watchdog enable not cleared");
   trip_map_a: assert property (@(posedge CLK) disable iff (!rst_n)
      (trip_sel_r[3:2] == 2'h3) |=> DIG_TRIP_MV == TRIP_MV_SEL3)
      else $error("digital trip level wrong");
endmodule

// >>> testbench/supply_comparator_model.sv
// Purpose: Comparator pair standing beside the supply monitor
// Assumes: Rail levels in mV are set by the bench
// Notes: Each output is 1 while its rail is above the selected trip level
`timescale 1ns/1ps
module supply_comparator_model (
   input wire logic [12:0] dig_mv,
   input wire logic [12:0] ana_mv,
   input wire logic [12:0] dig_trip_mv,
   input wire logic [12:0] ana_trip_mv,
   output logic dig_cmp,
   output logic ana_cmp
);
   assign dig_cmp = dig_mv > dig_trip_mv;
   assign ana_cmp = ana_mv > ana_trip_mv;
endmodule

// >>> testbench/supply_monitor_interrupt_tb_top.sv
// Purpose: Self-checking bench for the supply monitor flag logic
// Assumes: Short clear count and filter length for simulation
// Notes: Rail levels feed the comparator model; trip selections are swept for four passes, then random
`timescale 1ns/1ps
module supply_monitor_interrupt_tb_top;
   import supply_monitor_pkg::*;
   localparam int CC = 50;
   localparam int FL = 4;
   logic CLK = 1'b0;
   logic NRST = 1'b0;
   logic SFR_WR = 1'b0, SFR_RD = 1'b0, INT_ENABLE = 1'b0, DIG_CMP, ANA_CMP;
   logic LOW_SUPPLY_IRQ, WDOG_ENABLE_CLR;
   logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA, v;
   logic [12:0] DIG_TRIP_MV, ANA_TRIP_MV, dig_mv = 13'd5000, ana_mv = 13'd5000;
   logic [1:0] sd, sa;
   int error_cnt = 0, comparisons = 0, pulses = 0, n;
   ////////////////////////////////////////////////////////////////////////////
   supply_monitor_interrupt #(.CLEAR_COUNT(CC), .FILTER_LEN(FL)) supply_monitor_interrupt_inst (
      .CLK(CLK), .NRST(NRST), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR),
      .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .DIG_CMP(DIG_CMP), .ANA_CMP(ANA_CMP),
      .INT_ENABLE(INT_ENABLE), .DIG_TRIP_MV(DIG_TRIP_MV), .ANA_TRIP_MV(ANA_TRIP_MV),
      .LOW_SUPPLY_IRQ(LOW_SUPPLY_IRQ), .WDOG_ENABLE_CLR(WDOG_ENABLE_CLR));
   supply_comparator_model supply_comparator_model_inst (
      .dig_mv(dig_mv), .ana_mv(ana_mv), .dig_trip_mv(DIG_TRIP_MV), .ana_trip_mv(ANA_TRIP_MV),
      .dig_cmp(DIG_CMP), .ana_cmp(ANA_CMP));
   always #2 CLK = ~CLK;
   always @(posedge CLK) if (WDOG_ENABLE_CLR === 1'b1) pulses <= pulses + 1;
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [12:0] trip(input logic [1:0] s);
      return s == 2'b00 ? 13'd4630 : s == 2'b01 ? 13'd3080 : s == 2'b10 ? 13'd2930 : 13'd2630;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge CLK);
      #1;
   endtask
   // Each access lets an edge pass first so a strobe is never set twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cyc(1);
      SFR_ADDR = a;
      SFR_WDATA = d;
      SFR_WR = 1'b1;
      cyc(1);
      SFR_WR = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      cyc(1);
      SFR_ADDR = a;
      SFR_RD = 1'b1;
      cyc(1);
      SFR_RD = 1'b0;
      d = SFR_RDATA;
   endtask
   task automatic wait_irq(input logic lvl, input int lim);
      n = 0;
      while (LOW_SUPPLY_IRQ !== lvl && n < lim) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #20000;
      error_cnt++;
      give_verdict;
   end
   initial begin
      n = $urandom(42);
      cyc(8);
      NRST = 1'b1;
      cyc(4);
      rd(8'hdf, v);
      check(v, 8'hde);
      check(DIG_TRIP_MV, 13'd2630);
      check(ANA_TRIP_MV, 13'd2630);
      for (int i = 0; i < 8; i++) begin
         sd = (i < 4) ? 2'(i) : 2'($urandom_range(3));
         sa = (i < 4) ? 2'(3 - i) : 2'($urandom_range(3));
         dig_mv = 13'($urandom_range(5000, 2500));
         ana_mv = 13'($urandom_range(5000, 2500));
         wr(8'hdf, {3'b110, sd, sa, 1'b0});
         cyc(FL + 8);
         rd(8'hdf, v);
         check(v, {dig_mv > trip(sd), ana_mv > trip(sa), 1'b0, sd, sa, 1'b0});
         check(DIG_TRIP_MV, trip(sd));
         check(ANA_TRIP_MV, trip(sa));
      end
      dig_mv = 13'd5000;
      ana_mv = 13'd5000;
      INT_ENABLE = 1'b1;
      wr(8'hdf, 8'h1f);
      cyc(FL + 8);
      // Pulse shorter than the filter must leave the flag alone
      dig_mv = 13'd2000;
      cyc(FL - 2);
      dig_mv = 13'd5000;
      cyc(20);
      check(LOW_SUPPLY_IRQ, 1'b0);
      ana_mv = 13'd2000;
      wait_irq(1'b1, 60);
      check(LOW_SUPPLY_IRQ, 1'b1);
      // The pulse counter samples one edge after the pulse is launched
      cyc(1);
      check(pulses, 1);
      wr(8'hdf, 8'h1f);
      rd(8'hdf, v);
      check(v, 8'hbf);
      // Dip in mid-count, then the full clear time from the last return high
      ana_mv = 13'd5000;
      cyc(CC / 2);
      ana_mv = 13'd2000;
      cyc(FL + 6);
      ana_mv = 13'd5000;
      wait_irq(1'b0, 200);
      check(n >= CC && n <= CC + FL + 8, 1'b1);
      INT_ENABLE = 1'b0;
      wr(8'hdf, 8'h3f);
      rd(8'hdf, v);
      check(v, 8'hff);
      check(LOW_SUPPLY_IRQ, 1'b0);
      INT_ENABLE = 1'b1;
      cyc(2);
      check(LOW_SUPPLY_IRQ, 1'b1);
      check(pulses, 2);
      wr(8'hdf, 8'h1f);
      rd(8'hdf, v);
      check(v, 8'hdf);
      wr(8'he0, 8'h21);
      rd(8'he0, v);
      check(v, 8'h00);
      wr(8'hdf, 8'h1e);
      dig_mv = 13'd2000;
      cyc(FL + 10);
      rd(8'hdf, v);
      check(v, 8'h5e);
      check(LOW_SUPPLY_IRQ, 1'b0);
      give_verdict;
   end
endmodule
